//--- logic/cirb_device.sv
/*
  Serial slave register bank of a buck-boost converter: control, fault flags,
  identity and two output setpoints, reached over the two-wire link.
  Assumes a host that generates the link clock; all pins arrive unsynchronised.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cirb_device #(
  parameter bit         PREPROGRAMMED = 1'b1,
  parameter logic [3:0] VENDOR_CODE   = 4'hA,  // Arbitrary value
  parameter logic [1:0] MAJOR_REV     = 2'h0,
  parameter logic [1:0] MINOR_REV     = 2'h0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  cirb_i2c_if.device       link,
  input  wire logic        undervoltage_lockout_i,
  input  wire logic        enable_pin_i,
  input  wire logic        hot_die_i,
  input  wire logic        overcurrent_i,
  input  wire logic        thermal_shutdown_i,
  input  wire logic        power_not_good_i,
  output logic             range_high_o,
  output logic             converter_enable_o,
  output logic             forced_pulse_width_mode_o,
  output logic             ramp_pulse_width_mode_o,
  output logic [1:0]       slew_rate_o,
  output logic [6:0]       setpoint_low_o,
  output logic [6:0]       setpoint_high_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [cirb_pkg::SYNC_WIDTH-1:0] pins_w;
  logic [cirb_pkg::SYNC_WIDTH-1:0] sync1_r;
  logic [cirb_pkg::SYNC_WIDTH-1:0] sync2_r;

  assign pins_w = {link.scl, link.sda, undervoltage_lockout_i, enable_pin_i,
                   hot_die_i, overcurrent_i, thermal_shutdown_i, power_not_good_i};

  genvar gi;
  generate
    for (gi = 0; gi < cirb_pkg::SYNC_WIDTH; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        sync1_r[gi] <= pins_w[gi];
        sync2_r[gi] <= sync1_r[gi];
      end
    end
  endgenerate

  logic       scl_s;
  logic       sda_s;
  logic       lose_w;
  logic [3:0] cond_w;
  logic       scl_d_r;
  logic       sda_d_r;

  assign scl_s  = sync2_r[7];
  assign sda_s  = sync2_r[6];
  assign cond_w = sync2_r[3:0];
  assign lose_w = sync2_r[5] | ~sync2_r[4];

  always_ff @(posedge clk_i) begin
    scl_d_r <= scl_s;
    sda_d_r <= sda_s;
  end

  // ----------------------------------------------------------------
  // Link event decode
  // ----------------------------------------------------------------
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic fall_w;

  assign start_w = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_w  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign rise_w  = scl_s & ~scl_d_r;
  assign fall_w  = ~scl_s & scl_d_r;

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  cirb_pkg::cirb_dev_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic       ackph_r, ackph_nxt;
  logic       oe_r, oe_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] reg_addr_r, reg_addr_nxt;
  logic       rw_r, rw_nxt;
  logic       match_r, match_nxt;
  logic       hack_r, hack_nxt;
  logic [7:0] rd_value_w;
  logic       rd_load_w;
  logic       wr_pulse_w;
  logic       active_w;

  assign active_w = (state_r != cirb_pkg::ST_IDLE) && (state_r != cirb_pkg::ST_IGNORE);

  assign wr_pulse_w = fall_w & ackph_r & ~start_w & ~stop_w
                      & (state_r == cirb_pkg::ST_WDATA);
  // Load byte after address or host ACK
  assign rd_load_w = fall_w & ackph_r & ~start_w & ~stop_w
                     & (((state_r == cirb_pkg::ST_ADDR) & match_r & (rw_r == cirb_pkg::DIR_READ))
                     | ((state_r == cirb_pkg::ST_RDATA) & hack_r));

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    ackph_nxt    = ackph_r;
    oe_nxt       = oe_r;
    shift_nxt    = shift_r;
    tx_nxt       = tx_r;
    reg_addr_nxt = reg_addr_r;
    rw_nxt       = rw_r;
    match_nxt    = match_r;
    hack_nxt     = hack_r;
    if (start_w) begin
      state_nxt = cirb_pkg::ST_ADDR;
      cnt_nxt   = '0;
      ackph_nxt = 1'b0;
      oe_nxt    = 1'b0;
    end else if (stop_w) begin
      state_nxt = cirb_pkg::ST_IDLE;
      cnt_nxt   = '0;
      ackph_nxt = 1'b0;
      oe_nxt    = 1'b0;
    end else if (active_w && rise_w) begin
      if (cnt_r != cirb_pkg::ACK_BIT) begin
        shift_nxt = {shift_r[6:0], sda_s};
        cnt_nxt   = cnt_r + 4'h1;
      end else begin
        ackph_nxt = 1'b1;
        hack_nxt  = ~sda_s;
      end
    end else if (active_w && fall_w) begin
      if (ackph_r) begin
        ackph_nxt = 1'b0;
        cnt_nxt   = '0;
        oe_nxt    = 1'b0;
        unique case (state_r)
          cirb_pkg::ST_ADDR: begin
            if (!match_r) begin
              state_nxt = cirb_pkg::ST_IGNORE;
            end else if (rw_r == cirb_pkg::DIR_READ) begin
              state_nxt = cirb_pkg::ST_RDATA;
            end else begin
              state_nxt = cirb_pkg::ST_REGADDR;
            end
          end
          cirb_pkg::ST_REGADDR: state_nxt = cirb_pkg::ST_WDATA;
          // Further bytes go to next address
          cirb_pkg::ST_WDATA:   reg_addr_nxt = reg_addr_r + 8'h01;
          cirb_pkg::ST_RDATA: begin
            if (!hack_r) begin
              state_nxt = cirb_pkg::ST_IGNORE;
            end
          end
          default: state_nxt = cirb_pkg::ST_IGNORE;
        endcase
        if (rd_load_w) begin
          tx_nxt       = rd_value_w;
          oe_nxt       = ~rd_value_w[7];
          reg_addr_nxt = reg_addr_r + 8'h01;
        end
      end else if (cnt_r == cirb_pkg::ACK_BIT) begin
        unique case (state_r)
          cirb_pkg::ST_ADDR: begin
            match_nxt = (shift_r[7:1] == cirb_pkg::DEV_ADDR);
            rw_nxt    = shift_r[0];
            oe_nxt    = match_nxt;
          end
          cirb_pkg::ST_REGADDR: begin
            reg_addr_nxt = shift_r;
            oe_nxt       = 1'b1;
          end
          cirb_pkg::ST_WDATA: oe_nxt = 1'b1;
          cirb_pkg::ST_RDATA: oe_nxt = 1'b0;
          default:            oe_nxt = 1'b0;
        endcase
      end else if (state_r == cirb_pkg::ST_RDATA) begin
        tx_nxt = {tx_r[6:0], 1'b0};
        oe_nxt = ~tx_r[6];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= cirb_pkg::ST_IDLE;
      cnt_r      <= '0;
      ackph_r    <= 1'b0;
      oe_r       <= 1'b0;
      shift_r    <= '0;
      tx_r       <= '0;
      reg_addr_r <= '0;
      rw_r       <= 1'b0;
      match_r    <= 1'b0;
      hack_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      ackph_r    <= ackph_nxt;
      oe_r       <= oe_nxt;
      shift_r    <= shift_nxt;
      tx_r       <= tx_nxt;
      reg_addr_r <= reg_addr_nxt;
      rw_r       <= rw_nxt;
      match_r    <= match_nxt;
      hack_r     <= hack_nxt;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = oe_r;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [7:0] a, input logic [7:0] r);
    hits = (a == r);
  endfunction

  logic [7:0] ctrl_r;
  logic [3:0] flags_r;
  logic [7:0] sp_low_r;
  logic [7:0] sp_high_r;
  logic [7:0] identity_w;
  logic [3:0] flags_nxt;
  logic       regs_rst_w;
  logic       flags_read_w;

  assign regs_rst_w = rst_i | lose_w;
  assign identity_w = {VENDOR_CODE, MAJOR_REV, MINOR_REV};
  assign rd_value_w = hits(reg_addr_r, cirb_pkg::REG_CONTROL)       ? ctrl_r :
                      hits(reg_addr_r, cirb_pkg::REG_FAULT_FLAGS)   ? {4'h0, flags_r} :
                      hits(reg_addr_r, cirb_pkg::REG_DIE_IDENTITY)  ? identity_w :
                      hits(reg_addr_r, cirb_pkg::REG_SETPOINT_LOW)  ? sp_low_r :
                      hits(reg_addr_r, cirb_pkg::REG_SETPOINT_HIGH) ? sp_high_r :
                      cirb_pkg::UNMAPPED_READ;
  assign flags_read_w = rd_load_w & hits(reg_addr_r, cirb_pkg::REG_FAULT_FLAGS);
  // Read clears, live conditions set again
  assign flags_nxt = flags_read_w ? cond_w : (flags_r | cond_w);

  always_ff @(posedge clk_i) begin
    if (regs_rst_w) begin
      ctrl_r    <= PREPROGRAMMED ? cirb_pkg::CONTROL_RST_ON : cirb_pkg::CONTROL_RST_OFF;
      flags_r   <= cirb_pkg::FLAGS_RST;
      sp_low_r  <= cirb_pkg::SETPOINT_LOW_RST;
      sp_high_r <= cirb_pkg::SETPOINT_HIGH_RST;
    end else begin
      flags_r <= flags_nxt;
      if (wr_pulse_w && hits(reg_addr_r, cirb_pkg::REG_CONTROL)) begin
        ctrl_r <= shift_r & cirb_pkg::CONTROL_WR_MASK;
      end
      if (wr_pulse_w && hits(reg_addr_r, cirb_pkg::REG_SETPOINT_LOW)) begin
        sp_low_r <= shift_r & cirb_pkg::SETPOINT_WR_MASK;
      end
      if (wr_pulse_w && hits(reg_addr_r, cirb_pkg::REG_SETPOINT_HIGH)) begin
        sp_high_r <= shift_r & cirb_pkg::SETPOINT_WR_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter controls
  // ----------------------------------------------------------------
  // Range select
  assign range_high_o              = ctrl_r[cirb_pkg::CTL_RANGE];
  assign converter_enable_o        = ctrl_r[cirb_pkg::CTL_ENABLE];
  assign forced_pulse_width_mode_o = ctrl_r[cirb_pkg::CTL_FORCED_PWM];
  assign ramp_pulse_width_mode_o   = ctrl_r[cirb_pkg::CTL_RAMP_PWM];
  assign slew_rate_o               = ctrl_r[cirb_pkg::CTL_SLEW_HI:cirb_pkg::CTL_SLEW_LO];
  assign setpoint_low_o            = sp_low_r[6:0];
  assign setpoint_high_o           = sp_high_r[6:0];

endmodule
`default_nettype wire

//--- logic/cirb_host.sv
/*
  Host end of the converter register bank link: runs one single write or one
  single read per command. Assumes a device that never stretches the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cirb_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  cirb_i2c_if.host         link,
  input  wire logic [1:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o
);

  // ----------------------------------------------------------------
  // Command port
  // ----------------------------------------------------------------
  logic        busy_r;
  logic        nack_r;
  logic        cmd_rd_r;
  logic [7:0]  cmd_reg_r;
  logic [7:0]  cmd_data_r;
  logic [7:0]  rx_r;
  logic [7:0]  rdbyte_r;
  logic [31:0] rdata_r;
  logic        launch_w;
  logic [31:0] rd_mux_w;

  assign launch_w = wr_i & (addr_i == cirb_pkg::HOST_CMD) & ~busy_r;
  assign rd_mux_w = (addr_i == cirb_pkg::HOST_STATUS) ? {30'h0, nack_r, busy_r} :
                    (addr_i == cirb_pkg::HOST_RDATA)  ? {24'h0, rdbyte_r} :
                    32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (rd_i) begin
      rdata_r <= rd_mux_w;
    end
  end
  assign rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------
  logic                      sda_s1_r;
  logic                      sda_s2_r;
  logic [2:0]                step_r;
  logic [3:0]                bit_r;
  logic [1:0]                q_r;
  logic [6:0]                div_r;
  logic                      scl_oe_r;
  logic                      sda_oe_r;
  cirb_pkg::cirb_step_kind_t kind_w;
  logic [7:0]                byte_w;
  logic                      tick_w;
  logic                      last_bit_w;
  logic                      drive_low_w;

  always_ff @(posedge clk_i) begin
    sda_s1_r <= link.sda;
    sda_s2_r <= sda_s1_r;
  end

  always_comb begin
    kind_w = cirb_pkg::K_TX;
    byte_w = {cirb_pkg::DEV_ADDR, cirb_pkg::DIR_WRITE};
    unique case (step_r)
      3'h0: kind_w = cirb_pkg::K_START;
      3'h1: byte_w = {cirb_pkg::DEV_ADDR, cirb_pkg::DIR_WRITE};
      3'h2: byte_w = cmd_reg_r;
      3'h3: begin
        kind_w = cmd_rd_r ? cirb_pkg::K_START : cirb_pkg::K_TX;
        byte_w = cmd_data_r;
      end
      3'h4: begin
        kind_w = cmd_rd_r ? cirb_pkg::K_TX : cirb_pkg::K_STOP;
        byte_w = {cirb_pkg::DEV_ADDR, cirb_pkg::DIR_READ};
      end
      3'h5: kind_w = cirb_pkg::K_RX;
      default: kind_w = cirb_pkg::K_STOP;
    endcase
  end

  assign tick_w     = busy_r & (div_r == 7'(cirb_pkg::SCL_QUARTER_CYC - 1));
  assign last_bit_w = ((kind_w == cirb_pkg::K_START) || (kind_w == cirb_pkg::K_STOP))
                      ? 1'b1 : (bit_r == cirb_pkg::ACK_BIT);
  // Reading host answers not-acknowledge by releasing
  assign drive_low_w = (kind_w == cirb_pkg::K_STOP)
                       | ((kind_w == cirb_pkg::K_TX) & (bit_r <= cirb_pkg::LAST_DATA)
                          & ~byte_w[3'(cirb_pkg::LAST_DATA - bit_r)]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r     <= 1'b0;
      nack_r     <= 1'b0;
      cmd_rd_r   <= 1'b0;
      cmd_reg_r  <= '0;
      cmd_data_r <= '0;
      step_r     <= '0;
      bit_r      <= '0;
      q_r        <= '0;
      div_r      <= '0;
      scl_oe_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      rx_r       <= '0;
      rdbyte_r   <= '0;
    end else if (launch_w) begin
      busy_r     <= 1'b1;
      nack_r     <= 1'b0;
      cmd_rd_r   <= wdata_i[cirb_pkg::CMD_READ_BIT];
      cmd_reg_r  <= wdata_i[15:8];
      cmd_data_r <= wdata_i[7:0];
      step_r     <= '0;
      bit_r      <= '0;
      q_r        <= '0;
      div_r      <= '0;
    end else if (busy_r) begin
      div_r <= tick_w ? 7'h00 : div_r + 7'h01;
      if (tick_w) begin
        q_r <= q_r + 2'h1;
        unique case (q_r)
          2'h0: scl_oe_r <= 1'b1;
          2'h1: sda_oe_r <= drive_low_w;
          2'h2: scl_oe_r <= 1'b0;
          2'h3: begin
            if (kind_w == cirb_pkg::K_START) begin
              sda_oe_r <= 1'b1;
            end else if (kind_w == cirb_pkg::K_STOP) begin
              sda_oe_r <= 1'b0;
              busy_r   <= 1'b0;
            end else if (bit_r == cirb_pkg::ACK_BIT) begin
              // Device answer recorded, not acted on
              if (kind_w == cirb_pkg::K_TX) begin
                nack_r <= nack_r | sda_s2_r;
              end else begin
                rdbyte_r <= rx_r;
              end
            end else begin
              rx_r <= {rx_r[6:0], sda_s2_r};
            end
            bit_r <= last_bit_w ? 4'h0 : bit_r + 4'h1;
            if (last_bit_w) begin
              step_r <= step_r + 3'h1;
            end
          end
        endcase
      end
    end
  end

  // Open drain: the host only ever pulls either line low
  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_r;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = sda_oe_r;

endmodule
`default_nettype wire

//--- logic/cirb_i2c_if.sv
/*
  Two-wire link between the converter register bank and its host.
  Both lines are open drain; the resolved levels assume pull-ups on the board.
*/
`timescale 1ns/10ps
`default_nettype none
interface cirb_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND of every driver that pulls low
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

//--- logic/cirb_pkg.sv
/*
  Shared constants and types for the converter register bank: slave address,
  register offsets, field positions, reset values and the host command port map.
  Assumes a 250 MHz system clock on both ends of the serial link.
*/
package cirb_pkg;

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR   = 7'h75;
  localparam logic       DIR_WRITE  = 1'h0;
  localparam logic       DIR_READ   = 1'h1;
  localparam logic [3:0] ACK_BIT    = 4'h8;
  localparam logic [3:0] LAST_DATA  = 4'h7;
  localparam int         SYNC_WIDTH = 8;

  // ----------------------------------------------------------------
  // Register offsets and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONTROL       = 8'h01;
  localparam logic [7:0] REG_FAULT_FLAGS   = 8'h02;
  localparam logic [7:0] REG_DIE_IDENTITY  = 8'h03;
  localparam logic [7:0] REG_SETPOINT_LOW  = 8'h04;
  localparam logic [7:0] REG_SETPOINT_HIGH = 8'h05;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;
  localparam logic [7:0] CONTROL_RST_OFF   = 8'h00;
  localparam logic [7:0] CONTROL_RST_ON    = 8'h20;
  localparam logic [7:0] CONTROL_WR_MASK   = 8'h7F;
  localparam logic [3:0] FLAGS_RST         = 4'h0;
  localparam logic [7:0] SETPOINT_LOW_RST  = 8'h3C;
  localparam logic [7:0] SETPOINT_HIGH_RST = 8'h42;
  localparam logic [7:0] SETPOINT_WR_MASK  = 8'h7F;
  localparam int         CTL_RANGE         = 6;
  localparam int         CTL_ENABLE        = 5;
  localparam int         CTL_FORCED_PWM    = 3;
  localparam int         CTL_RAMP_PWM      = 2;
  localparam int         CTL_SLEW_HI       = 1;
  localparam int         CTL_SLEW_LO       = 0;

  // ----------------------------------------------------------------
  // Host command port
  // ----------------------------------------------------------------
  localparam logic [1:0] HOST_CMD       = 2'h0;
  localparam logic [1:0] HOST_STATUS    = 2'h1;
  localparam logic [1:0] HOST_RDATA     = 2'h2;
  localparam int         CMD_READ_BIT   = 16;
  localparam int         SCL_QUARTER_NS = 250;
  localparam int         CLK_MHZ        = 250;
  localparam int         SCL_QUARTER_CYC = (SCL_QUARTER_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ADDR    = 3'h1,
    ST_REGADDR = 3'h3,
    ST_WDATA   = 3'h2,
    ST_RDATA   = 3'h6,
    ST_IGNORE  = 3'h7
  } cirb_dev_state_t;

  typedef enum logic [1:0] {
    K_START = 2'h0,
    K_TX    = 2'h1,
    K_RX    = 2'h3,
    K_STOP  = 2'h2
  } cirb_step_kind_t;

endpackage

//--- tb/cirb_link_asserts.sv
/*
  Wire-level checks on the two-wire link between host and converter bank.
  Assumes plain inputs from the link interface and the shared 250 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cirb_link_asserts (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic host_sda_oe_i,
  input  wire logic dev_sda_oe_i
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic [5:0] bit_cnt_r;
  logic [5:0] bit_cnt_nxt;
  wire        start_w = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire        rise_w  = scl_i & ~scl_q_r;
  // Ninth clock of the first, second or third byte after a START
  wire        ninth_w = (bit_cnt_r == 6'h08) | (bit_cnt_r == 6'h11) | (bit_cnt_r == 6'h1A);

  // Clock rises since the last START, saturating
  assign bit_cnt_nxt = start_w ? 6'h00 :
                       (rise_w && bit_cnt_r != 6'h3F) ? bit_cnt_r + 6'h01 : bit_cnt_r;

  always_ff @(posedge clk_i) begin
    scl_q_r   <= rst_i ? 1'b1 : scl_i;
    sda_q_r   <= rst_i ? 1'b1 : sda_i;
    bit_cnt_r <= rst_i ? 6'h00 : bit_cnt_nxt;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence

  a_start_by_host: assert property (s_start |-> host_sda_oe_i)
    else $error("start not made by host");
  a_start_dev_quiet: assert property (s_start |-> !dev_sda_oe_i [*8])
    else $error("device drives data at start");
  a_stop_dev_free: assert property (s_stop |-> ##1 !dev_sda_oe_i [*8])
    else $error("device drives data after stop");
  a_dev_moves_low: assert property ($rose(dev_sda_oe_i) |-> !scl_i)
    else $error("device pulls data while clock high");
  a_dev_data_stable: assert property (scl_i && $past(scl_i) |-> $stable(dev_sda_oe_i))
    else $error("device data changes while clock high");
  a_ack_ninth_bit: assert property ($rose(dev_sda_oe_i) && bit_cnt_r < 6'h09 |->
                                    bit_cnt_r == 6'h08)
    else $error("first device pull not after eighth bit");
  a_ack_held: assert property ($rose(dev_sda_oe_i) |-> dev_sda_oe_i [*8])
    else $error("device pull too short");
  a_host_ninth_free: assert property ($rose(scl_i) && ninth_w |-> !host_sda_oe_i)
    else $error("host drives data on ninth bit");
  a_scl_low_time: assert property ($fell(scl_i) |-> ##[120:132] $rose(scl_i))
    else $error("clock low phase out of range");
  a_scl_high_time: assert property ($rose(scl_i) |-> scl_i [*8])
    else $error("clock high phase too short");
endmodule
`default_nettype wire

//--- tb/cirb_tb_top.sv
/*
  Self-checking bench: host and converter bank joined over the link interface.
  Assumes both ends share the 250 MHz clock and a pulled-up link.
*/
`timescale 1ns/10ps
`default_nettype none
module cirb_tb_top;
  localparam logic [3:0] VC = 4'h9;  // Arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  addr_i = 2'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        lockout = 1'b0;
  logic        en_pin = 1'b1;
  logic        hot_die = 1'b0;
  logic        overcurrent = 1'b0;
  logic        thermal = 1'b0;
  logic        pwr_bad = 1'b0;
  logic [31:0] rdata_o;
  logic        range_high, conv_en, forced_pwm, ramp_pwm;
  logic [1:0]  slew;
  logic [6:0]  sp_low, sp_high;
  logic [31:0] v;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  cirb_i2c_if link();
  cirb_host u_cirb_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  cirb_device #(.VENDOR_CODE(VC), .MAJOR_REV(2'h2), .MINOR_REV(2'h1)) u_cirb_device (
    .clk_i(clk_i), .rst_i(rst_i), .link(link), .undervoltage_lockout_i(lockout),
    .enable_pin_i(en_pin), .hot_die_i(hot_die), .overcurrent_i(overcurrent),
    .thermal_shutdown_i(thermal), .power_not_good_i(pwr_bad), .range_high_o(range_high),
    .converter_enable_o(conv_en), .forced_pulse_width_mode_o(forced_pwm),
    .ramp_pulse_width_mode_o(ramp_pwm), .slew_rate_o(slew), .setpoint_low_o(sp_low),
    .setpoint_high_o(sp_high));
  cirb_link_asserts u_cirb_link_asserts (.clk_i(clk_i), .rst_i(rst_i), .scl_i(link.scl),
    .sda_i(link.sda), .host_sda_oe_i(link.host_sda_oe), .dev_sda_oe_i(link.dev_sda_oe));

  always #2 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic port_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic cmd(input logic rd, input logic [7:0] ra, input logic [7:0] wd);
    int n;
    logic [31:0] st;
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= cirb_pkg::HOST_CMD;
    wdata_i <= {15'h0, rd, ra, wd};
    @(posedge clk_i);
    wr_i <= 1'b0;
    st = 32'h1;
    for (n = 0; n < 8000 && st[0] !== 1'b0; n++) begin
      port_rd(cirb_pkg::HOST_STATUS, st);
    end
    chk(st, 32'h0);
  endtask

  task automatic rd_reg(input logic [7:0] ra, output logic [31:0] d);
    cmd(1'b1, ra, 8'h00);
    port_rd(cirb_pkg::HOST_RDATA, d);
  endtask

  task automatic pins(input logic u, input logic e);
    @(posedge clk_i);
    lockout <= u;
    en_pin  <= e;
    repeat (8) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_control;
    cmd(1'b0, cirb_pkg::REG_CONTROL, 8'hFF);
    chk({range_high, conv_en, forced_pwm, ramp_pwm, slew}, 32'h3F);
    rd_reg(cirb_pkg::REG_CONTROL, v);
    chk(v, 32'h7F);
  endtask

  task automatic t_unmapped_and_id;
    rd_reg(8'h07, v);
    chk(v, 32'h00);
    cmd(1'b0, cirb_pkg::REG_DIE_IDENTITY, 8'h00);
    rd_reg(cirb_pkg::REG_DIE_IDENTITY, v);
    chk(v, {24'h0, VC, 2'h2, 2'h1});
  endtask

  task automatic t_flags;
    @(posedge clk_i);
    {hot_die, overcurrent, thermal, pwr_bad} <= 4'hF;
    repeat (10) @(posedge clk_i);
    {hot_die, overcurrent, thermal} <= 3'h0;
    rd_reg(cirb_pkg::REG_FAULT_FLAGS, v);
    chk(v, 32'h0F);
    @(posedge clk_i);
    pwr_bad <= 1'b0;
    rd_reg(cirb_pkg::REG_FAULT_FLAGS, v);
    chk(v, 32'h01);
  endtask

  task automatic t_volatile;
    @(posedge clk_i);
    hot_die <= 1'b1;
    repeat (4) @(posedge clk_i);
    hot_die <= 1'b0;
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    chk({range_high, conv_en, forced_pwm, ramp_pwm, slew}, 32'h10);
    rd_reg(cirb_pkg::REG_FAULT_FLAGS, v);
    chk(v, 32'h00);
    cmd(1'b0, cirb_pkg::REG_SETPOINT_LOW, 8'h91);
    chk(sp_low, 32'h11);
    pins(1'b0, 1'b0);
    pins(1'b0, 1'b1);
    chk(sp_low, {25'h0, cirb_pkg::SETPOINT_LOW_RST[6:0]});
    chk(sp_high, {25'h0, cirb_pkg::SETPOINT_HIGH_RST[6:0]});
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_control();
    t_unmapped_and_id();
    t_flags();
    t_volatile();
    wrap_up();
  end
endmodule
`default_nettype wire
